// ### ccpwm_assertions.sv
`timescale 1ns/1ps
module ccpwm_chk (
   // Clock and reset.
   input wire logic        clk,
   input wire logic        sys_rst,
   // Register bus.
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Requests.
   input wire logic        overflow_irq_req,
   input wire logic [1:0]  channel_irq_req
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [3:0] wr_age_q; // Cycles since write data was last taken.
   // Age counter; a request may only drop shortly after a write.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) wr_age_q <= 4'hf;
      else if (s_axi_wvalid && s_axi_wready) wr_age_q <= 4'h0;
      else if (wr_age_q != 4'hf) wr_age_q <= wr_age_q + 4'h1;
   end
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_wr_refuse: assert property (s_wr_taken |=> !s_axi_awready && !s_axi_wready)
      else $error("write ready not dropped");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer not held");
   a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
      else $error("read answer late");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_unmapped_err: assert property (s_rd_taken and s_axi_araddr > 8'h18 |=>
      s_axi_rresp == ccpwm_pkg::RESP_SLV && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
      else $error("read data upper half not zero");
   a_ovf_req_hold: assert property ($fell(overflow_irq_req) |-> wr_age_q < 4'h8)
      else $error("overflow request dropped without write");
   a_ch_req_hold: assert property ($fell(channel_irq_req[1]) |-> wr_age_q < 4'h8)
      else $error("channel request dropped without write");
endmodule // ccpwm_chk
bind ccpwm_top ccpwm_chk u_chk (.*);

// ### ccpwm_pins.sv
`timescale 1ns/1ps
module ccpwm_pins (
   // Clock.
   input wire logic  clk,
   // Pin levels offered to the unit.
   output logic [1:0] chan_pin_in,
   output logic       ext_count_clock_pin
);
   // Quiet levels at time zero; the count clock stands still between bursts.
   initial begin
      chan_pin_in = 2'h0;
      ext_count_clock_pin = 1'b0;
   end
   // One rising then falling edge on a channel pin, long enough to survive sync.
   task automatic pulse(input int ch);
      @(posedge clk);
      chan_pin_in[ch] <= 1'b1;
      repeat (8) @(posedge clk);
      chan_pin_in[ch] <= 1'b0;
   endtask
   // Rising edges on the count clock, slower than half the bus rate.
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk);
         ext_count_clock_pin <= 1'b1;
         repeat (4) @(posedge clk);
         ext_count_clock_pin <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
endmodule // ccpwm_pins

// ### ccpwm_pkg.sv
// Functional notes
// - Sixteen-bit up-counter, free-running or modulo.
// - Counter reads never disturb counting.
// - Three-bit select picks divider or external clock.
// - Active capture edge copies counter to channel.
// - Capture raises channel request when enabled.
// - Compare match sets, clears or toggles pin.
// - Compare match raises channel request when enabled.
// - Unbuffered value writes take effect at once.
// - Link bit joins channels onto channel 0 pin.
// - Last written value set takes over at overflow.
// - Linked pair uses channel 0 control; pin 1 released.
// - Toggle on overflow makes modulo-period PWM.
// - PWM period is modulo plus one ticks.
// - Mode and edge/level field decodes as specified.
// - Link bit wins over other mode bit.
// - Without overflow toggle, clear on compare stays at 0% duty.
// - Max duty plus overflow toggle gives 100% duty.
// - Overflow sets flag, counter restarts from zero.
// - Channel flag set on capture or compare.
package ccpwm_pkg;
   // -----------------------------------------------------------------
   // Register byte offsets.
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_STATUS  = 8'h00; // Unit status and control.
   localparam logic [7:0] OFS_COUNT   = 8'h04; // Counter value, read only.
   localparam logic [7:0] OFS_MODULO  = 8'h08; // Counter modulo value.
   localparam logic [7:0] OFS_CH0_CTL = 8'h0c; // Channel 0 control.
   localparam logic [7:0] OFS_CH0_VAL = 8'h10; // Channel 0 value.
   localparam logic [7:0] OFS_CH1_CTL = 8'h14; // Channel 1 control.
   localparam logic [7:0] OFS_CH1_VAL = 8'h18; // Channel 1 value.
   // -----------------------------------------------------------------
   // Field positions.
   // -----------------------------------------------------------------
   localparam int B_FLAG  = 7; // Overflow flag or channel event flag.
   localparam int B_IE    = 6; // Interrupt enable.
   localparam int B_HALT  = 5; // Counter halt in the status register.
   localparam int B_CRST  = 4; // Counter reset, write only.
   localparam int B_MODEB = 5; // Mode select high bit (link on channel 0).
   localparam int B_MODEA = 4; // Mode select low bit.
   localparam int B_ELSB  = 3; // Edge/level select high bit.
   localparam int B_ELSA  = 2; // Edge/level select low bit.
   localparam int B_TOV   = 1; // Toggle on overflow.
   localparam int B_MAX   = 0; // Maximum duty force.
   // -----------------------------------------------------------------
   // Reset values and encodings.
   // -----------------------------------------------------------------
   localparam logic [15:0] MODULO_RST = 16'hffff; // Free-running.
   localparam logic [2:0]  PS_EXT     = 3'h7;     // External clock code.
   localparam logic [1:0]  ELS_TOGGLE = 2'h1;     // Toggle on compare.
   localparam logic [1:0]  ELS_CLEAR  = 2'h2;     // Clear on compare.
   localparam logic [1:0]  ELS_SET    = 2'h3;     // Set on compare.
   localparam logic [1:0]  RESP_OKAY  = 2'h0;     // Bus answer: okay.
   localparam logic [1:0]  RESP_SLV   = 2'h2;     // Bus answer: error.
   localparam logic [6:0]  PRE_ONES   = 7'h7f;    // Divider mask base.
endpackage

// ### ccpwm_top.sv
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module ccpwm_top (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Write address channel.
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // Write data channel.
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // Write response channel.
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // Read address channel.
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // Read data channel.
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Channel pins and external count clock.
   input  wire logic [1:0]  chan_pin_in,
   output logic [1:0]       chan_pin_out,
   output logic [1:0]       chan_pin_oe,
   input  wire logic        ext_count_clock_pin,
   // Interrupt requests.
   output logic             overflow_irq_req,
   output logic [1:0]       channel_irq_req
);
   // ----------------------------------------------------------------
   // Decode helpers.
   // ----------------------------------------------------------------
   // Tells whether a byte address hits one of the seven registers.
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a[1:0] == 2'h0) && (a <= ccpwm_pkg::OFS_CH1_VAL);
   endfunction

   // Merges a 16-bit value with the low two byte lanes of a write.
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // ----------------------------------------------------------------
   // Bus slave state.
   // ----------------------------------------------------------------
   logic [7:0]  aw_addr_q;   // Held write address.
   logic        aw_v_q;      // Write address held.
   logic [31:0] w_data_q;    // Held write data.
   logic [3:0]  w_strb_q;    // Held write strobes.
   logic        w_v_q;       // Write data held.
   logic        awready_q;   // Address ready.
   logic        wready_q;    // Data ready.
   logic        bvalid_q;    // Response pending.
   logic [1:0]  bresp_q;     // Response code.
   logic        arready_q;   // Read address ready.
   logic        rvalid_q;    // Read data pending.
   logic [31:0] rdata_q;     // Read data.
   logic [1:0]  rresp_q;     // Read response code.

   wire aw_take  = s_axi_awvalid & awready_q;
   wire w_take   = s_axi_wvalid & wready_q;
   wire wr_fire  = aw_v_q & w_v_q & ~bvalid_q;
   wire aw_v_n   = (aw_v_q | aw_take) & ~wr_fire;
   wire w_v_n    = (w_v_q | w_take) & ~wr_fire;
   wire ar_take  = s_axi_arvalid & arready_q;
   wire rvalid_n = ar_take | (rvalid_q & ~s_axi_rready);
   wire wr_ok    = wr_fire & is_mapped(aw_addr_q);
   wire rd_ok    = ar_take & is_mapped(s_axi_araddr);

   // Per-register write and read strobes.
   // Control and status writes need byte lane 0 of the held strobes.
   wire wr_stat = wr_ok & w_strb_q[0] & (aw_addr_q == ccpwm_pkg::OFS_STATUS);
   wire wr_mod  = wr_ok & (aw_addr_q == ccpwm_pkg::OFS_MODULO);
   wire rd_stat = rd_ok & (s_axi_araddr == ccpwm_pkg::OFS_STATUS);

   // Accepts address and data in either order and answers once both
   // are held; one read and one write may be under way together.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_v_q    <= 1'b0;
         w_v_q     <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= ccpwm_pkg::RESP_OKAY;
      end else begin
         aw_v_q    <= aw_v_n;
         w_v_q     <= w_v_n;
         awready_q <= ~aw_v_n;
         wready_q  <= ~w_v_n;
         if (aw_take) begin
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         // Unmapped addresses answer with a slave error.
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? ccpwm_pkg::RESP_OKAY : ccpwm_pkg::RESP_SLV;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Counter, prescaler and unit status.
   // ----------------------------------------------------------------
   logic [15:0] cnt_q;       // Counter value.
   logic [15:0] mod_q;       // Counter modulo value.
   logic [6:0]  pre_q;       // Prescaler divider.
   logic [2:0]  ps_q;        // Prescale select.
   logic        halt_q;      // Counter halt.
   logic        ovf_ie_q;    // Overflow interrupt enable.
   logic        ovf_flag_q;  // Overflow flag.
   logic        ovf_arm_q;   // Flag read while set, clear allowed.
   logic [2:0]  ext_s_q;     // External clock synchroniser and delay.

   wire [7:0] wd8      = w_data_q[7:0];
   wire       crst     = wr_stat & wd8[ccpwm_pkg::B_CRST];
   wire [6:0] pre_mask = ccpwm_pkg::PRE_ONES >> (ccpwm_pkg::PS_EXT - ps_q);
   wire       ext_rise = ext_s_q[1] & ~ext_s_q[2];
   // Tick from the selected divider tap or the external clock.
   wire       tick     = (ps_q == ccpwm_pkg::PS_EXT) ? ext_rise
                         : ((pre_q & pre_mask) == pre_mask);
   wire       tick_run = tick & ~halt_q;
   wire       ovf_ev   = tick_run & (cnt_q == mod_q);

   // Prescaler always runs unless halted or reset by software.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pre_q   <= 7'h00;
         ext_s_q <= 3'h0;
      end else begin
         ext_s_q <= {ext_s_q[1:0], ext_count_clock_pin};
         if (crst) begin
            pre_q <= 7'h00;
         end else if (~halt_q) begin
            pre_q <= pre_q + 7'h01;
         end
      end
   end

   // Counts up to the modulo value, then restarts from zero.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= 16'h0000;
      end else if (crst) begin
         cnt_q <= 16'h0000;
      end else if (ovf_ev) begin
         cnt_q <= 16'h0000;
      end else if (tick_run) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // Status fields, modulo value and the overflow flag handshake.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mod_q      <= ccpwm_pkg::MODULO_RST;
         ps_q       <= 3'h0;
         halt_q     <= 1'b1;
         ovf_ie_q   <= 1'b0;
         ovf_flag_q <= 1'b0;
         ovf_arm_q  <= 1'b0;
      end else begin
         if (wr_mod) begin
            mod_q <= merge16(mod_q, w_data_q, w_strb_q);
         end
         if (wr_stat) begin
            ps_q     <= wd8[2:0];
            halt_q   <= wd8[ccpwm_pkg::B_HALT];
            ovf_ie_q <= wd8[ccpwm_pkg::B_IE];
         end
         // A new overflow wins over a clear in the same cycle.
         if (ovf_ev) begin
            ovf_flag_q <= 1'b1;
            ovf_arm_q  <= 1'b0;
         end else if (wr_stat & ovf_arm_q & ~wd8[ccpwm_pkg::B_FLAG]) begin
            ovf_flag_q <= 1'b0;
            ovf_arm_q  <= 1'b0;
         end else if (rd_stat & ovf_flag_q) begin
            ovf_arm_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Channels.
   // ----------------------------------------------------------------
   logic [7:0]  ctl_q [2];   // Channel control fields.
   logic [15:0] val_q [2];   // Channel value registers.
   logic        last_q;      // Value set written last in linked mode.
   logic        sel_q;       // Value set now driving the linked output.

   // Link bit on channel 0 wins over its other mode bit.
   wire link = ctl_q[0][ccpwm_pkg::B_MODEB];

   // Tracks which value set drives the linked output; hand-over only
   // happens at overflow.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         last_q <= 1'b0;
         sel_q  <= 1'b0;
      end else begin
         if (wr_ok & (aw_addr_q == ccpwm_pkg::OFS_CH0_VAL)) begin
            last_q <= 1'b0;
         end else if (wr_ok & (aw_addr_q == ccpwm_pkg::OFS_CH1_VAL)) begin
            last_q <= 1'b1;
         end
         if (~link) begin
            sel_q <= 1'b0;
         end else if (ovf_ev) begin
            sel_q <= last_q;
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_ch
         logic [2:0] pin_s_q;  // Pin synchroniser and edge delay.
         logic       arm_q;    // Flag read while set.
         logic       pin_q;    // Pin output level.
         logic       oe_q;     // Pin output enable.
         logic       irq_q;    // Request output.

         wire [7:0]  c       = ctl_q[gi];
         wire [7:0]  ctl_ofs = (gi == 0) ? ccpwm_pkg::OFS_CH0_CTL
                                         : ccpwm_pkg::OFS_CH1_CTL;
         wire [7:0]  val_ofs = (gi == 0) ? ccpwm_pkg::OFS_CH0_VAL
                                         : ccpwm_pkg::OFS_CH1_VAL;
         // Channel 1 is idle while the pair is linked.
         wire        active  = (gi == 0) | ~link;
         wire [1:0]  els     = c[ccpwm_pkg::B_ELSB:ccpwm_pkg::B_ELSA];
         // Both mode bits clear selects capture.
         wire        capmode = ~c[ccpwm_pkg::B_MODEB] & ~c[ccpwm_pkg::B_MODEA];
         wire [15:0] cmp_val = ((gi == 0) & sel_q) ? val_q[1] : val_q[gi];
         wire        rise    = pin_s_q[1] & ~pin_s_q[2];
         wire        fall    = ~pin_s_q[1] & pin_s_q[2];
         // Captures are held off while the counter is halted.
         wire        cap_ev  = active & capmode & ~halt_q
                               & ((els[0] & rise) | (els[1] & fall));
         wire        match   = active & ~capmode & tick_run
                               & (cnt_q == cmp_val);
         wire        ev      = cap_ev | match;
         wire        wr_ctl  = wr_ok & w_strb_q[0] & (aw_addr_q == ctl_ofs);
         wire        wr_val  = wr_ok & (aw_addr_q == val_ofs);
         wire        rd_ctl  = rd_ok & (s_axi_araddr == ctl_ofs);
         wire        tov     = c[ccpwm_pkg::B_TOV];
         wire        force_h = tov & c[ccpwm_pkg::B_MAX];

         // Control, value and event flag; an event beats a clear.
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               ctl_q[gi] <= 8'h00;
               val_q[gi] <= 16'h0000;
               arm_q     <= 1'b0;
               pin_s_q   <= 3'h0;
            end else begin
               pin_s_q <= {pin_s_q[1:0], chan_pin_in[gi]};
               if (wr_ctl) begin
                  ctl_q[gi][6:0] <= wd8[6:0];
               end
               if (cap_ev) begin
                  val_q[gi] <= cnt_q;
               end else if (wr_val) begin
                  val_q[gi] <= merge16(val_q[gi], w_data_q, w_strb_q);
               end
               if (ev) begin
                  ctl_q[gi][ccpwm_pkg::B_FLAG] <= 1'b1;
                  arm_q <= 1'b0;
               end else if (wr_ctl & arm_q & ~wd8[ccpwm_pkg::B_FLAG]) begin
                  ctl_q[gi][ccpwm_pkg::B_FLAG] <= 1'b0;
                  arm_q <= 1'b0;
               end else if (rd_ctl & c[ccpwm_pkg::B_FLAG]) begin
                  arm_q <= 1'b1;
               end
            end
         end

         // Drives the pin in compare mode; toggle on overflow takes precedence
         // over a compare landing on the same tick.
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               pin_q <= 1'b0;
               oe_q  <= 1'b0;
               irq_q <= 1'b0;
            end else begin
               oe_q  <= active & ~capmode & (els != 2'h0);
               irq_q <= c[ccpwm_pkg::B_FLAG] & c[ccpwm_pkg::B_IE];
               if (~active | capmode) begin
                  pin_q <= pin_q;
               end else if (force_h) begin
                  pin_q <= ~els[0];
               end else if (ovf_ev & tov) begin
                  pin_q <= ~pin_q;
               end else if (match) begin
                  case (els)
                     ccpwm_pkg::ELS_TOGGLE: pin_q <= ~pin_q;
                     ccpwm_pkg::ELS_CLEAR:  pin_q <= 1'b0;
                     ccpwm_pkg::ELS_SET:    pin_q <= 1'b1;
                     default:               pin_q <= pin_q;
                  endcase
               end
            end
         end

         assign chan_pin_out[gi]    = pin_q;
         assign chan_pin_oe[gi]     = oe_q;
         assign channel_irq_req[gi] = irq_q;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read path.
   // ----------------------------------------------------------------
   logic [31:0] rd_word;     // Selected register contents.
   logic        ovf_irq_q;   // Overflow request.

   wire [7:0] stat_rd = {ovf_flag_q, ovf_ie_q, halt_q, 2'h0, ps_q};

   // Selects the register; counter reads have no side effect.
   always_comb begin
      case (s_axi_araddr)
         ccpwm_pkg::OFS_STATUS:  rd_word = {24'h000000, stat_rd};
         ccpwm_pkg::OFS_COUNT:   rd_word = {16'h0000, cnt_q};
         ccpwm_pkg::OFS_MODULO:  rd_word = {16'h0000, mod_q};
         ccpwm_pkg::OFS_CH0_CTL: rd_word = {24'h000000, ctl_q[0]};
         ccpwm_pkg::OFS_CH0_VAL: rd_word = {16'h0000, val_q[0]};
         ccpwm_pkg::OFS_CH1_CTL: rd_word = {24'h000000, ctl_q[1]};
         ccpwm_pkg::OFS_CH1_VAL: rd_word = {16'h0000, val_q[1]};
         default:                rd_word = 32'h0000_0000;
      endcase
   end

   // Captures read data and the overflow request.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= ccpwm_pkg::RESP_OKAY;
         ovf_irq_q <= 1'b0;
      end else begin
         arready_q <= ~rvalid_n;
         rvalid_q  <= rvalid_n;
         ovf_irq_q <= ovf_flag_q & ovf_ie_q;
         if (ar_take) begin
            rdata_q <= rd_word;
            rresp_q <= rd_ok ? ccpwm_pkg::RESP_OKAY : ccpwm_pkg::RESP_SLV;
         end
      end
   end

   assign s_axi_awready    = awready_q;
   assign s_axi_wready     = wready_q;
   assign s_axi_bvalid     = bvalid_q;
   assign s_axi_bresp      = bresp_q;
   assign s_axi_arready    = arready_q;
   assign s_axi_rvalid     = rvalid_q;
   assign s_axi_rdata      = rdata_q;
   assign s_axi_rresp      = rresp_q;
   assign overflow_irq_req = ovf_irq_q;
endmodule // ccpwm_top

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, ext_count_clock_pin, overflow_irq_req;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, chan_pin_out, chan_pin_oe, channel_irq_req, pin_drv, r;
   int error_cnt, checked, hi, ri;
   // The pin wire carries the unit's drive where enabled, else the far side's.
   wire logic [1:0] chan_pin_in = (chan_pin_oe & chan_pin_out) | (~chan_pin_oe & pin_drv);
   ccpwm_top uut (.*);
   ccpwm_pins pins (.clk(clk), .chan_pin_in(pin_drv), .ext_count_clock_pin(ext_count_clock_pin));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Verdict and end of run.
   task automatic give_verdict();
      if (error_cnt == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // Write: address and data offered together, each released once taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50 && (n == 0 || s_axi_awvalid || s_axi_wvalid || s_axi_bready); n++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) s_axi_bready <= 1'b0;
      end
      if (n >= 50) begin
         error_cnt++;
         give_verdict();
      end
   endtask
   // Read: address held until taken, data taken at the edge with rvalid.
   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50 && (n == 0 || s_axi_rready); n++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
         end
      end
      if (n >= 50) begin
         error_cnt++;
         give_verdict();
      end
   endtask
   // Counts high samples and rising edges of channel 0 over a window.
   task automatic win(input int w);
      logic last;
      repeat (60) @(posedge clk);
      #1;
      hi = 0;
      ri = 0;
      last = chan_pin_out[0];
      repeat (w) begin
         @(posedge clk);
         #1;
         hi += 32'(chan_pin_out[0]);
         ri += 32'(chan_pin_out[0] && !last);
         last = chan_pin_out[0];
      end
   endtask
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      s_axi_awaddr = 8'h0;
      s_axi_araddr = 8'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      error_cnt = 0;
      checked = 0;
      sys_rst = 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(ccpwm_pkg::OFS_STATUS);
      check("status reset", d, 32'h20);
      rd(ccpwm_pkg::OFS_MODULO);
      check("modulo reset", d, 32'hffff);
      rd(8'h40);
      check("unmapped resp", 32'(r), 32'(ccpwm_pkg::RESP_SLV));
      // Clear-on-compare PWM, modulo 9, width 4, over three prescales.
      wr(ccpwm_pkg::OFS_STATUS, 32'h30);
      wr(ccpwm_pkg::OFS_MODULO, 32'h9);
      wr(ccpwm_pkg::OFS_CH0_VAL, 32'h3);
      wr(ccpwm_pkg::OFS_CH0_CTL, 32'h1a);
      for (int ps = 0; ps < 3; ps++) begin
         wr(ccpwm_pkg::OFS_STATUS, 32'(ps));
         win(400);
         check("pwm high", hi, 160);
         check("pwm periods", ri, 40 >> ps);
      end
      check("ch0 drive", 32'(chan_pin_oe[0]), 32'h1);
      rd(ccpwm_pkg::OFS_STATUS);
      check("overflow flag", 32'(d[7]), 32'h1);
      rd(ccpwm_pkg::OFS_COUNT);
      check("count in range", 32'(d <= 32'h9), 32'h1);
      wr(ccpwm_pkg::OFS_STATUS, 32'h0);
      wr(ccpwm_pkg::OFS_CH0_CTL, 32'h1e);
      win(200);
      check("set pwm high", hi, 120);
      wr(ccpwm_pkg::OFS_CH0_CTL, 32'h18);
      win(200);
      check("zero duty", hi, 0);
      wr(ccpwm_pkg::OFS_CH0_CTL, 32'h14);
      win(200);
      check("toggle high", hi, 100);
      wr(ccpwm_pkg::OFS_CH0_CTL, 32'h1b);
      win(200);
      check("full duty", hi, 200);
      // Linked pair: channel 0 first, then whichever value was written last.
      wr(ccpwm_pkg::OFS_CH0_CTL, 32'h3a);
      wr(ccpwm_pkg::OFS_CH1_CTL, 32'h18);
      win(200);
      check("link ch0 width", hi, 80);
      check("ch1 released", 32'(chan_pin_oe[1]), 32'h0);
      wr(ccpwm_pkg::OFS_CH1_VAL, 32'h6);
      win(200);
      check("link ch1 width", hi, 140);
      wr(ccpwm_pkg::OFS_CH0_VAL, 32'h2);
      win(200);
      check("link back width", hi, 60);
      // Overflow request raised, then cleared by read and write of zero.
      wr(ccpwm_pkg::OFS_STATUS, 32'h40);
      repeat (20) @(posedge clk);
      check("overflow request", 32'(overflow_irq_req), 32'h1);
      wr(ccpwm_pkg::OFS_STATUS, 32'h60);
      rd(ccpwm_pkg::OFS_STATUS);
      wr(ccpwm_pkg::OFS_STATUS, 32'h60);
      repeat (3) @(posedge clk);
      check("overflow cleared", 32'(overflow_irq_req), 32'h0);
      // Rising-edge capture on channel 1 with its request enabled.
      wr(ccpwm_pkg::OFS_CH1_CTL, 32'h44);
      wr(ccpwm_pkg::OFS_CH0_CTL, 32'h0);
      wr(ccpwm_pkg::OFS_MODULO, 32'hffff);
      wr(ccpwm_pkg::OFS_STATUS, 32'h30);
      wr(ccpwm_pkg::OFS_STATUS, 32'h0);
      pins.pulse(1);
      repeat (10) @(posedge clk);
      rd(ccpwm_pkg::OFS_CH1_VAL);
      check("capture value", 32'(d > 32'h0 && d < 32'h64), 32'h1);
      check("capture request", 32'(channel_irq_req[1]), 32'h1);
      // External count clock: five edges give a count of five.
      wr(ccpwm_pkg::OFS_STATUS, 32'h37);
      wr(ccpwm_pkg::OFS_STATUS, 32'h07);
      pins.ticks(5);
      repeat (6) @(posedge clk);
      rd(ccpwm_pkg::OFS_COUNT);
      check("ext count", d, 32'h5);
      give_verdict();
   end
endmodule // testbench
